// ===== rtl/dcdl_ctrl.sv
// Delay loop controller: configuration registers, status and readback
`timescale 1ns/10ps
module dcdl_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  input  wire logic [4:0]  phase_meas,
  output logic [5:0]       coarse_delay,
  output logic [7:0]       fine_delay,
  output logic             loop_power_down,
  output logic             lock_achieved_flag
);
  import dcdl_pkg::*;

  dcdl_top_t  s;
  dcdl_top_t  next_s;
  logic [13:0] dly;
  logic        locked;
  logic        lost_p;
  logic        fail_p;
  logic [7:0]  rd_mux;

  // ********************
  // Loop engine
  // ********************
  dcdl_loop u_loop (
    .sys_clk (sys_clk),
    .rst     (rst),
    .cfg     (s.cfg),
    .meas    (s.meas_s2),
    .dly     (dly),
    .locked  (locked),
    .lost_p  (lost_p),
    .fail_p  (fail_p)
  );

  // ********************
  // Register read mux
  // ********************
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      DCDL_ADR_PD:     rd_mux = {7'h00, s.cfg.loop_power_down};
      DCDL_ADR_CTRL:   rd_mux = {s.cfg.track_restart, s.cfg.search_stop,
                                 s.cfg.slope_pos, s.cfg.search_dir,
                                 s.cfg.mode, s.cfg.enable};
      DCDL_ADR_STAT:   rd_mux = {5'h00, s.fail, s.lost, locked};
      DCDL_ADR_GUARD:  rd_mux = {4'h0, s.cfg.guard};
      DCDL_ADR_COARSE: rd_mux = {2'h0, s.cfg.coarse};
      DCDL_ADR_FINE:   rd_mux = s.cfg.fine;
      DCDL_ADR_PHASE:  rd_mux = {3'h0, s.cfg.desired_phase_value};
      DCDL_ADR_BW:     rd_mux = {3'h0, s.cfg.phase_filter_bandwidth,
                                 s.cfg.tracking_speed};
      DCDL_ADR_RBREQ:  rd_mux = {7'h00, s.rb_req};
      DCDL_ADR_RBCRS:  rd_mux = {2'h0, s.rb_coarse};
      DCDL_ADR_RBFIN:  rd_mux = s.rb_fine;
      DCDL_ADR_RBPHS:  rd_mux = {3'h0, s.rb_phase};
      default:         rd_mux = 8'h00;
    endcase
  end

  // ********************
  // Next state
  // ********************
  always_comb begin
    next_s         = s;
    next_s.meas_s1 = phase_meas;
    next_s.meas_s2 = s.meas_s1;
    if (reg_rd) begin
      next_s.rdata = rd_mux;
    end
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        DCDL_ADR_PD: next_s.cfg.loop_power_down = reg_wdata[0];
        DCDL_ADR_CTRL: begin
          next_s.cfg.track_restart = reg_wdata[DCDL_B_TRK_ERR];
          next_s.cfg.search_stop   = reg_wdata[DCDL_B_SRC_ERR];
          next_s.cfg.slope_pos     = reg_wdata[DCDL_B_SLOPE];
          next_s.cfg.search_dir    = reg_wdata[DCDL_B_SRC_LO +: 2];
          next_s.cfg.mode          = reg_wdata[DCDL_B_MODE_LO +: 2];
          next_s.cfg.enable        = reg_wdata[DCDL_B_ENABLE];
        end
        DCDL_ADR_STAT:   next_s.lost = reg_wdata[DCDL_B_LOST];
        DCDL_ADR_GUARD:  next_s.cfg.guard = reg_wdata[3:0];
        DCDL_ADR_COARSE: next_s.cfg.coarse = reg_wdata[5:0];
        DCDL_ADR_FINE:   next_s.cfg.fine = reg_wdata;
        DCDL_ADR_PHASE:  next_s.cfg.desired_phase_value = reg_wdata[4:0];
        DCDL_ADR_BW: begin
          next_s.cfg.phase_filter_bandwidth = reg_wdata[DCDL_B_BW_LO +: 3];
          next_s.cfg.tracking_speed         = reg_wdata[1:0];
        end
        DCDL_ADR_RBREQ: begin
          next_s.rb_req = reg_wdata[0];
          if (reg_wdata[0] && !s.rb_req) begin
            next_s.rb_coarse = dly[13:8];
            next_s.rb_fine   = dly[7:0];
            next_s.rb_phase  = s.meas_s2;
          end
        end
        default: next_s.rdata = next_s.rdata;
      endcase
    end
    // Failure flag clears when the controller is disabled; set wins
    if (!s.cfg.enable) begin
      next_s.fail = 1'b0;
    end
    if (fail_p) begin
      next_s.fail = 1'b1;
    end
    if (lost_p) begin
      next_s.lost = 1'b1;
    end
  end

  // ********************
  // State register
  // ********************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '{cfg: '{track_restart: DCDL_RST_TRK_ERR,
                    search_stop: DCDL_RST_SRC_ERR,
                    slope_pos: DCDL_RST_SLOPE,
                    search_dir: DCDL_RST_SEARCH,
                    mode: DCDL_RST_MODE,
                    enable: 1'b0,
                    guard: DCDL_RST_GUARD,
                    coarse: DCDL_RST_COARSE,
                    fine: DCDL_RST_FINE,
                    desired_phase_value: DCDL_RST_PHASE,
                    phase_filter_bandwidth: DCDL_RST_BW,
                    tracking_speed: DCDL_RST_WEIGHT,
                    loop_power_down: DCDL_RST_PD},
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata          = s.rdata;
  assign coarse_delay       = dly[13:8];
  assign fine_delay         = dly[7:0];
  assign loop_power_down    = s.cfg.loop_power_down;
  assign lock_achieved_flag = locked;

endmodule : dcdl_ctrl

// ===== rtl/dcdl_pkg.sv
// Package: register map, field layouts and state types of the delay loop
package dcdl_pkg;

  // ********************
  // Register offsets
  // ********************
  localparam logic [11:0] DCDL_ADR_PD     = 12'h090;
  localparam logic [11:0] DCDL_ADR_CTRL   = 12'h091;
  localparam logic [11:0] DCDL_ADR_STAT   = 12'h092;
  localparam logic [11:0] DCDL_ADR_GUARD  = 12'h093;
  localparam logic [11:0] DCDL_ADR_COARSE = 12'h094;
  localparam logic [11:0] DCDL_ADR_FINE   = 12'h095;
  localparam logic [11:0] DCDL_ADR_PHASE  = 12'h096;
  localparam logic [11:0] DCDL_ADR_BW     = 12'h097;
  localparam logic [11:0] DCDL_ADR_RBREQ  = 12'h098;
  localparam logic [11:0] DCDL_ADR_RBCRS  = 12'h099;
  localparam logic [11:0] DCDL_ADR_RBFIN  = 12'h09A;
  localparam logic [11:0] DCDL_ADR_RBPHS  = 12'h09B;

  // ********************
  // Field positions
  // ********************
  localparam int DCDL_B_TRK_ERR = 7;
  localparam int DCDL_B_SRC_ERR = 6;
  localparam int DCDL_B_SLOPE   = 5;
  localparam int DCDL_B_SRC_LO  = 3;
  localparam int DCDL_B_MODE_LO = 1;
  localparam int DCDL_B_ENABLE  = 0;
  localparam int DCDL_B_FAIL    = 2;
  localparam int DCDL_B_LOST    = 1;
  localparam int DCDL_B_LOCK    = 0;
  localparam int DCDL_B_BW_LO   = 2;

  // ********************
  // Reset values
  // ********************
  localparam logic       DCDL_RST_PD      = 1'b1;
  localparam logic       DCDL_RST_TRK_ERR = 1'b1;
  localparam logic       DCDL_RST_SRC_ERR = 1'b1;
  localparam logic       DCDL_RST_SLOPE   = 1'b0;
  localparam logic [1:0] DCDL_RST_SEARCH  = 2'h2;
  localparam logic [1:0] DCDL_RST_MODE    = 2'h0;
  localparam logic [3:0] DCDL_RST_GUARD   = 4'h0;
  localparam logic [5:0] DCDL_RST_COARSE  = 6'h00;
  localparam logic [7:0] DCDL_RST_FINE    = 8'h80;
  localparam logic [4:0] DCDL_RST_PHASE   = 5'h08;
  localparam logic [2:0] DCDL_RST_BW      = 3'h0;
  localparam logic [1:0] DCDL_RST_WEIGHT  = 2'h0;
  localparam logic [13:0] DCDL_DLY_MAX    = 14'h3FFF;

  // ********************
  // Mode and direction codes
  // ********************
  localparam logic [1:0] DCDL_MODE_SRCH_TRK = 2'h0;
  localparam logic [1:0] DCDL_MODE_TRK_ONLY = 2'h1;
  localparam logic [1:0] DCDL_MODE_SRCH_ONLY = 2'h2;
  localparam logic [1:0] DCDL_DIR_DOWN = 2'h0;
  localparam logic [1:0] DCDL_DIR_UP   = 2'h1;

  // Software configuration
  typedef struct packed {
    logic       track_restart;
    logic       search_stop;
    logic       slope_pos;
    logic [1:0] search_dir;
    logic [1:0] mode;
    logic       enable;
    logic [3:0] guard;
    logic [5:0] coarse;
    logic [7:0] fine;
    logic [4:0] desired_phase_value;
    logic [2:0] phase_filter_bandwidth;
    logic [1:0] tracking_speed;
    logic       loop_power_down;
  } dcdl_cfg_t;

  typedef enum logic [2:0] {
    DCDL_ST_IDLE   = 3'b000,
    DCDL_ST_SEARCH = 3'b001,
    DCDL_ST_TRACK  = 3'b010,
    DCDL_ST_HOLD   = 3'b011,
    DCDL_ST_FAIL   = 3'b100
  } dcdl_fsm_t;

  // Loop engine state
  typedef struct packed {
    dcdl_fsm_t   fsm;
    logic [13:0] dly;
    logic [7:0]  cnt;
    logic        dir_up;
    logic        second_leg;
    logic        locked;
    logic        lost_p;
    logic        fail_p;
  } dcdl_loop_t;

  // Top state
  typedef struct packed {
    dcdl_cfg_t  cfg;
    logic       lost;
    logic       fail;
    logic       rb_req;
    logic [5:0] rb_coarse;
    logic [7:0] rb_fine;
    logic [4:0] rb_phase;
    logic [7:0] rdata;
    logic [4:0] meas_s1;
    logic [4:0] meas_s2;
  } dcdl_top_t;

endpackage : dcdl_pkg

// ===== rtl/dcdl_loop.sv
// Closed-loop delay search and tracking engine
`timescale 1ns/10ps
module dcdl_loop (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire dcdl_pkg::dcdl_cfg_t cfg,
  input  wire logic [4:0]         meas,
  output logic [13:0]             dly,
  output logic                    locked,
  output logic                    lost_p,
  output logic                    fail_p
);
  import dcdl_pkg::*;

  dcdl_loop_t s;
  dcdl_loop_t next_s;
  logic [13:0] setp;
  logic [13:0] step;
  logic [4:0]  diff;
  logic        in_band;
  logic        go_up;

  // Settle time between samples, widened by the filter bandwidth
  function automatic logic [7:0] settle(input logic [2:0] bw);
    settle = 8'h01 << bw;
  endfunction : settle

  // Error magnitude, guard band test and tracking direction
  always_comb begin
    setp    = {cfg.coarse, cfg.fine};
    step    = 14'h0001 << cfg.tracking_speed;
    diff    = (meas > cfg.desired_phase_value) ?
              meas - cfg.desired_phase_value :
              cfg.desired_phase_value - meas;
    in_band = {3'h0, diff} <= {4'h0, cfg.guard};
    go_up   = (meas < cfg.desired_phase_value) == cfg.slope_pos;
  end

  // Next state of the engine
  always_comb begin
    next_s        = s;
    next_s.lost_p = 1'b0;
    next_s.fail_p = 1'b0;
    if (!cfg.enable || cfg.loop_power_down) begin
      next_s.fsm    = DCDL_ST_IDLE;
      next_s.dly    = setp;
      next_s.locked = 1'b0;
      next_s.cnt    = 8'h00;
    end else begin
      case (s.fsm)
        DCDL_ST_IDLE: begin
          next_s.dly        = setp;
          next_s.cnt        = settle(cfg.phase_filter_bandwidth);
          next_s.dir_up     = (cfg.search_dir == DCDL_DIR_UP);
          next_s.second_leg = 1'b0;
          next_s.fsm        = (cfg.mode == DCDL_MODE_TRK_ONLY) ?
                              DCDL_ST_TRACK : DCDL_ST_SEARCH;
        end
        DCDL_ST_SEARCH: begin
          if (s.cnt != 8'h00) begin
            next_s.cnt = s.cnt - 8'h01;
          end else begin
            next_s.cnt = settle(cfg.phase_filter_bandwidth);
            if (in_band) begin
              next_s.locked = 1'b1;
              next_s.fsm    = (cfg.mode == DCDL_MODE_SRCH_ONLY) ?
                              DCDL_ST_HOLD : DCDL_ST_TRACK;
            end else if (s.dir_up ? s.dly == DCDL_DLY_MAX
                                  : s.dly == 14'h0000) begin
              if (cfg.search_dir != DCDL_DIR_DOWN &&
                  cfg.search_dir != DCDL_DIR_UP && !s.second_leg) begin
                next_s.second_leg = 1'b1;
                next_s.dir_up     = 1'b1;
                next_s.dly        = setp;
              end else begin
                next_s.fail_p = 1'b1;
                next_s.fsm    = cfg.search_stop ?
                                DCDL_ST_FAIL : DCDL_ST_IDLE;
              end
            end else begin
              next_s.dly = s.dir_up ? s.dly + 14'h0001
                                    : s.dly - 14'h0001;
            end
          end
        end
        DCDL_ST_TRACK: begin
          if (s.cnt != 8'h00) begin
            next_s.cnt = s.cnt - 8'h01;
          end else begin
            next_s.cnt = settle(cfg.phase_filter_bandwidth);
            if (in_band) begin
              next_s.locked = 1'b1;
            end else begin
              if (s.locked) begin
                next_s.lost_p = 1'b1;
                next_s.locked = 1'b0;
                if (cfg.track_restart &&
                    cfg.mode != DCDL_MODE_TRK_ONLY) begin
                  next_s.fsm = DCDL_ST_IDLE;
                end
              end
              // Saturating step toward the desired phase
              if (go_up) begin
                next_s.dly = (DCDL_DLY_MAX - s.dly < step) ?
                             DCDL_DLY_MAX : s.dly + step;
              end else begin
                next_s.dly = (s.dly < step) ? 14'h0000
                                            : s.dly - step;
              end
            end
          end
        end
        DCDL_ST_HOLD: next_s.fsm = DCDL_ST_HOLD;
        DCDL_ST_FAIL: next_s.fsm = DCDL_ST_FAIL;
        default:      next_s.fsm = DCDL_ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '{fsm: DCDL_ST_IDLE, dly: {DCDL_RST_COARSE, DCDL_RST_FINE},
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign dly    = s.dly;
  assign locked = s.locked;
  assign lost_p = s.lost_p;
  assign fail_p = s.fail_p;

endmodule : dcdl_loop

// ===== sim/dcdl_ctrl_properties.sv
// Checker: port-level properties of the delay loop controller
`timescale 1ns/10ps
module dcdl_ctrl_properties
  import dcdl_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [4:0]  phase_meas,
  input wire logic [5:0]  coarse_delay,
  input wire logic [7:0]  fine_delay,
  input wire logic        loop_power_down,
  input wire logic        lock_achieved_flag
);
  // ****
  // Shadows of software settings
  // ****
  logic       en_sh;
  logic [5:0] crs_sp;
  logic [7:0] fin_sp;
  logic       wr_pd;
  logic       rd_any;
  assign wr_pd  = reg_wr && reg_addr == DCDL_ADR_PD;
  assign rd_any = reg_rd;
  // Track enable and setpoints as written
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_sh  <= 1'b0;
      crs_sp <= DCDL_RST_COARSE;
      fin_sp <= DCDL_RST_FINE;
    end else if (reg_wr) begin
      if (reg_addr == DCDL_ADR_CTRL) en_sh <= reg_wdata[DCDL_B_ENABLE];
      if (reg_addr == DCDL_ADR_COARSE) crs_sp <= reg_wdata[5:0];
      if (reg_addr == DCDL_ADR_FINE) fin_sp <= reg_wdata;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_COARSE_FOLLOW: assert property (($stable(crs_sp) && !en_sh)[*4]
    |-> coarse_delay == crs_sp) else $error("coarse delay off setpoint");
  AST_FINE_FOLLOW: assert property (($stable(fin_sp) && !en_sh)[*4]
    |-> fine_delay == fin_sp) else $error("fine delay off setpoint");
  AST_RESET_VALUES: assert property (disable iff (1'b0) rst |=>
    (coarse_delay == 6'h00 && fine_delay == 8'h80 && loop_power_down
     && !lock_achieved_flag && reg_rdata == 8'h00))
    else $error("bad value after reset");
  AST_PD_WRITE: assert property (wr_pd ##1 !wr_pd |=>
    loop_power_down == $past(reg_wdata[0], 2))
    else $error("power-down not as written");
  AST_LOCK_OFF: assert property (!en_sh[*5] |-> !lock_achieved_flag)
    else $error("lock shown while controller off");
  AST_STAT_READ: assert property (rd_any && reg_addr == DCDL_ADR_STAT
    && $stable(lock_achieved_flag) |=> reg_rdata[7:3] == 5'h00
    && reg_rdata[0] == $past(lock_achieved_flag))
    else $error("status read disagrees with lock");
  AST_COARSE_READ: assert property (rd_any && reg_addr == DCDL_ADR_COARSE
    |=> reg_rdata == {2'b00, $past(crs_sp)}) else $error("coarse read");
  AST_FINE_READ: assert property (rd_any && reg_addr == DCDL_ADR_FINE
    |=> reg_rdata == $past(fin_sp)) else $error("fine read");
  AST_UNMAPPED: assert property (rd_any && (reg_addr < DCDL_ADR_PD
    || reg_addr > DCDL_ADR_RBPHS) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Main scenarios reached
  COV_LOCK: cover property ($rose(lock_achieved_flag));
  COV_UNLOCK: cover property (en_sh && $fell(lock_achieved_flag));
  COV_PD_OFF: cover property ($fell(loop_power_down));
endmodule : dcdl_ctrl_properties

bind dcdl_ctrl dcdl_ctrl_properties u_dcdl_ctrl_properties (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .phase_meas(phase_meas), .coarse_delay(coarse_delay),
  .fine_delay(fine_delay), .loop_power_down(loop_power_down),
  .lock_achieved_flag(lock_achieved_flag));

// ===== sim/dcdl_ctrl_tb.sv
// Testbench: self-checking stimulus for the delay loop controller
`timescale 1ns/10ps
module dcdl_ctrl_tb;
  import dcdl_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [4:0]  phase_meas = 5'h0B;
  logic [7:0]  reg_rdata;
  logic [5:0]  coarse_delay;
  logic [7:0]  fine_delay;
  logic        loop_power_down;
  logic        lock_achieved_flag;
  int          err_total = 0;
  int          num_checks = 0;
  logic [31:0] seed = 32'd79;
  logic [7:0]  rv;
  logic [11:0] rw_adr [6] = '{DCDL_ADR_PD, DCDL_ADR_GUARD, DCDL_ADR_COARSE,
                              DCDL_ADR_FINE, DCDL_ADR_PHASE, DCDL_ADR_BW};
  logic [7:0]  rst_tab [14] = '{8'h00, 8'h01, 8'hD0, 8'h00, 8'h00, 8'h00,
    8'h80, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  always #12.5 sys_clk = ~sys_clk;

  dcdl_ctrl u_dcdl_ctrl (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .phase_meas(phase_meas),
    .coarse_delay(coarse_delay), .fine_delay(fine_delay),
    .loop_power_down(loop_power_down),
    .lock_achieved_flag(lock_achieved_flag));

  // ****
  // Expectation helpers and bus tasks
  // ****
  function automatic logic [7:0] mask_of(input logic [11:0] a);
    case (a)
      DCDL_ADR_PD:                  mask_of = 8'h01;
      DCDL_ADR_GUARD:               mask_of = 8'h0F;
      DCDL_ADR_COARSE:              mask_of = 8'h3F;
      DCDL_ADR_PHASE, DCDL_ADR_BW:  mask_of = 8'h1F;
      default:                      mask_of = 8'hFF;
    endcase
  endfunction : mask_of
  function automatic logic [7:0] rand8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rand8 = seed[7:0];
  endfunction : rand8
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(posedge sys_clk);
    #1 d = reg_rdata;
  endtask : rd
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rd_chk
  task automatic wait_lock(input logic v);
    int n;
    n = 0;
    while (lock_achieved_flag !== v && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    chk(lock_achieved_flag, v);
  endtask : wait_lock
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog against a hung run
  initial begin
    #(25 * 30000);
    err_total++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 14; i++)
      rd_chk(12'h08F + 12'(i), rst_tab[i]);
    for (int i = 0; i < 24; i++) begin
      rv = rand8();
      wr(rw_adr[i % 6], rv);
      rd_chk(rw_adr[i % 6], rv & mask_of(rw_adr[i % 6]));
      if (i % 6 == 0) chk(loop_power_down, rv[0]);
      if (i % 6 == 2) chk(coarse_delay, rv[5:0]);
      if (i % 6 == 3) chk(fine_delay, rv);
      wr(12'h09C, rv);
      rd_chk(12'h09C, 8'h00);
    end
    // Readback capture only on a rising request
    wr(DCDL_ADR_COARSE, 8'h15);
    wr(DCDL_ADR_FINE, 8'h3C);
    wr(DCDL_ADR_RBREQ, 8'h01);
    rd_chk(DCDL_ADR_RBCRS, 8'h15);
    rd_chk(DCDL_ADR_RBFIN, 8'h3C);
    rd_chk(DCDL_ADR_RBPHS, 8'h0B);
    wr(DCDL_ADR_COARSE, 8'h2A);
    wr(DCDL_ADR_RBREQ, 8'h01);
    rd_chk(DCDL_ADR_RBCRS, 8'h15);
    wr(DCDL_ADR_RBREQ, 8'h00);
    wr(DCDL_ADR_RBREQ, 8'h01);
    rd_chk(DCDL_ADR_RBCRS, 8'h2A);
    // Loop powered, search fails at each bound
    wr(DCDL_ADR_PD, 8'h00);
    wr(DCDL_ADR_PHASE, 8'h08);
    wr(DCDL_ADR_GUARD, 8'h00);
    wr(DCDL_ADR_BW, 8'h00);
    for (int k = 0; k < 2; k++) begin
      phase_meas <= 5'h18;
      wr(DCDL_ADR_COARSE, k ? 8'h3F : 8'h00);
      wr(DCDL_ADR_FINE, k ? 8'hFC : 8'h04);
      wr(DCDL_ADR_CTRL, 8'hC1 | 8'(k << 3));
      rv = 8'h00;
      for (int n = 0; n < 60 && rv[2] !== 1'b1; n++)
        rd(DCDL_ADR_STAT, rv);
      chk(rv, 8'h04);
      chk({coarse_delay, fine_delay}, k ? 14'h3FFF : 14'h0000);
      wr(DCDL_ADR_CTRL, 8'hD0);
      rd_chk(DCDL_ADR_STAT, 8'h00);
    end
    // Lock in band, then lose it
    wr(DCDL_ADR_COARSE, 8'h10);
    wr(DCDL_ADR_FINE, 8'h80);
    wr(DCDL_ADR_GUARD, 8'h02);
    phase_meas <= 5'h09;
    wr(DCDL_ADR_CTRL, 8'hD9);
    wait_lock(1'b1);
    rd_chk(DCDL_ADR_STAT, 8'h01);
    phase_meas <= 5'h1F;
    wait_lock(1'b0);
    rd(DCDL_ADR_STAT, rv);
    chk(rv & 8'h02, 8'h02);
    wr(DCDL_ADR_STAT, 8'h00);
    rd(DCDL_ADR_STAT, rv);
    chk(rv & 8'h02, 8'h00);
    wr(DCDL_ADR_CTRL, 8'hD0);
    // Search only keeps its lock
    phase_meas <= 5'h08;
    wr(DCDL_ADR_CTRL, 8'hD5);
    wait_lock(1'b1);
    phase_meas <= 5'h1F;
    repeat (40) @(posedge sys_clk);
    chk(lock_achieved_flag, 1'b1);
    // Track only never reports a search failure
    wr(DCDL_ADR_CTRL, 8'hD0);
    wr(DCDL_ADR_CTRL, 8'hD3);
    repeat (60) @(posedge sys_clk);
    rd(DCDL_ADR_STAT, rv);
    chk(rv & 8'h04, 8'h00);
    // Reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(DCDL_ADR_CTRL, 8'hD0);
    rd_chk(DCDL_ADR_PD, 8'h01);
    tally_and_finish();
  end
endmodule : dcdl_ctrl_tb
